// ---- src/lock_detect_pkg.sv ----
/*
 * Constants for the loop-two lock detector and second status pin block:
 * register offsets, field positions, reset values, selector and pin type codes.
 * Assumes a byte-wide register port with a 9-bit address.
 */
package lock_detect_pkg;

    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 14;
    localparam int SEL_W = 5;
    localparam int TYPE_W = 3;

    // Register offsets
    localparam logic [8:0] OFF_LOCK_COUNT_HIGH = 9'h16a;
    localparam logic [8:0] OFF_LOCK_COUNT_LOW = 9'h16b;
    localparam logic [8:0] OFF_STATUS_PIN_TWO_CONFIG = 9'h16e;
    localparam logic [8:0] OFF_LOST_CLEAR = 9'h182;
    localparam logic [8:0] OFF_LOCK_READBACK = 9'h183;
    localparam logic [8:0] OFF_STATUS_ONE_SELECT = 9'h190;
    localparam logic [8:0] OFF_IRQ_STATUS = 9'h191;
    localparam logic [8:0] OFF_IRQ_ENABLE = 9'h192;
    localparam logic [8:0] OFF_IRQ_CLEAR = 9'h193;

    // Field positions
    localparam int COUNT_HIGH_MSB = 5;
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 3;
    localparam int TYPE_MSB = 2;
    localparam int TYPE_LSB = 0;
    localparam int RB_LOOP_TWO_LOCK = 0;
    localparam int RB_LOST_FLAG = 1;
    localparam int RB_LOOP_ONE_LOCK = 2;
    localparam int IRQ_LOCK_GAINED = 0;
    localparam int IRQ_LOCK_LOST = 1;
    localparam int IRQ_W = 2;

    // Reset values
    localparam logic [5:0] RST_COUNT_HIGH = 6'h00;
    localparam logic [7:0] RST_COUNT_LOW = 8'h00;
    localparam logic [4:0] RST_SEL_TWO = 5'h00;
    localparam logic [2:0] RST_TYPE_TWO = 3'h6;
    localparam logic [4:0] RST_SEL_ONE = 5'h00;

    // Status pin source codes
    localparam logic [4:0] SRC_LOW = 5'h00;
    localparam logic [4:0] SRC_LOOP_ONE_LOCK = 5'h01;
    localparam logic [4:0] SRC_LOOP_TWO_LOCK = 5'h02;
    localparam logic [4:0] SRC_BOTH_LOCK = 5'h03;
    localparam logic [4:0] SRC_HOLDOVER = 5'h04;
    localparam logic [4:0] SRC_DAC_LOCKED = 5'h05;
    localparam logic [4:0] SRC_RESERVED = 5'h06;
    localparam logic [4:0] SRC_READBACK = 5'h07;
    localparam logic [4:0] SRC_DAC_RAIL = 5'h08;
    localparam logic [4:0] SRC_DAC_LOW = 5'h09;
    localparam logic [4:0] SRC_DAC_HIGH = 5'h0a;
    localparam logic [4:0] SRC_ONE_N = 5'h0b;
    localparam logic [4:0] SRC_ONE_N_HALF = 5'h0c;
    localparam logic [4:0] SRC_TWO_N = 5'h0d;
    localparam logic [4:0] SRC_TWO_N_HALF = 5'h0e;
    localparam logic [4:0] SRC_ONE_R = 5'h0f;
    localparam logic [4:0] SRC_ONE_R_HALF = 5'h10;
    localparam logic [4:0] SRC_TWO_R = 5'h11;
    localparam logic [4:0] SRC_TWO_R_HALF = 5'h12;

    // Pin output types
    localparam logic [2:0] TYPE_PUSH_PULL = 3'h3;
    localparam logic [2:0] TYPE_PUSH_PULL_INV = 3'h4;
    localparam logic [2:0] TYPE_OPEN_DRAIN = 3'h6;

    // Divider indices for the half-rate toggles
    localparam int DIV_ONE_N = 0;
    localparam int DIV_TWO_N = 1;
    localparam int DIV_ONE_R = 2;
    localparam int DIV_TWO_R = 3;
    localparam int DIV_COUNT = 4;

    // True when a selector routes loop-two lock detect on its own
    function automatic logic routes_loop_two(input logic [4:0] sel);
        return sel == SRC_LOOP_TWO_LOCK;
    endfunction

    // True when a selector uses loop-two lock detect at all
    function automatic logic uses_loop_two(input logic [4:0] sel);
        return (sel == SRC_LOOP_TWO_LOCK) || (sel == SRC_BOTH_LOCK);
    endfunction

endpackage

// ---- src/lock_counter.sv ----
/*
 * Consecutive in-window comparison counter that produces digital lock detect.
 * Assumes one comparison result per i_compare_valid pulse from the phase detector.
 */
`timescale 1ns/1ps
module lock_counter #(
    parameter int COUNT_W = 14
) (
    input wire logic i_clock, // System clock
    input wire logic i_rst, // Synchronous reset, active high
    input wire logic i_compare_valid, // One comparison completed this cycle
    input wire logic i_in_window, // That comparison fell inside the window
    input wire logic [COUNT_W-1:0] i_threshold, // Programmed cycle count
    output logic o_lock // Digital lock detect
);
    logic [COUNT_W-1:0] count_q, count_d;
    logic lock_q, lock_d;

    // Count saturates at the threshold so a long lock never wraps
    always_comb begin
        count_d = count_q;
        if (i_threshold == '0) begin
            count_d = '0; // Zero threshold is invalid, never locks
        end else if (i_compare_valid && !i_in_window) begin
            count_d = '0;
        end else if (i_compare_valid && count_q < i_threshold) begin
            count_d = count_q + COUNT_W'(1);
        end
        lock_d = (i_threshold != '0) && (count_d >= i_threshold);
    end

    // State registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_q <= '0;
            lock_q <= 1'b0;
        end else begin
            count_q <= count_d;
            lock_q <= lock_d;
        end
    end

    assign o_lock = lock_q;
endmodule // lock_counter

// ---- src/status_pin_driver.sv ----
/*
 * Output stage of a status pin: push-pull, inverted push-pull or open drain.
 * Assumes the pad resolves the level from pin value and enable outside.
 */
`timescale 1ns/1ps
module status_pin_driver (
    input wire logic i_clock, // System clock
    input wire logic i_rst, // Synchronous reset, active high
    input wire logic i_level, // Selected source level
    input wire logic [2:0] i_type, // Output type code
    output logic o_pin, // Pin drive value
    output logic o_pin_oe // Pin output enable
);
    import lock_detect_pkg::*;

    logic pin_q, pin_d;
    logic oe_q, oe_d;

    // Reserved type codes leave the pin undriven rather than guess a mode
    always_comb begin
        pin_d = 1'b0;
        oe_d = 1'b0;
        case (i_type)
            TYPE_PUSH_PULL: begin
                pin_d = i_level;
                oe_d = 1'b1;
            end
            TYPE_PUSH_PULL_INV: begin
                pin_d = !i_level;
                oe_d = 1'b1;
            end
            TYPE_OPEN_DRAIN: begin
                pin_d = 1'b0;
                oe_d = !i_level;
            end
            default: begin
                pin_d = 1'b0;
                oe_d = 1'b0;
            end
        endcase
    end

    // Registered so the pad sees no glitches from the selector
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pin_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
            oe_q <= oe_d;
        end
    end

    assign o_pin = pin_q;
    assign o_pin_oe = oe_q;
endmodule // status_pin_driver

// ---- src/lock_detect_status_select.sv ----
/*
 * Loop-two lock detect configuration, second status pin source and type
 * selection, lock-lost flag, readback and interrupt logic.
 * Assumes a byte-wide register port (read data one cycle after the strobe)
 * and that all status sources are synchronous to i_clock.
 */
// Design decision made here: strobed register access.

// Operation
// - Fourteen-bit lock threshold: high six bits at lock_count_high, low byte at lock_count_low.
// - Lock asserts after threshold consecutive in-window comparisons; zero never locks.
// - Pin two source selector bits 7:3, reset 0, codes 0 to 7.
// - Codes 8 to 18 route DAC flags and loop-one/loop-two dividers and halves.
// - Pin two type bits 2:0, reset 6: push-pull, inverted, open drain.
// - Loop-two lock readback valid only while a selector routes code 2.
// - Lock-lost flag sets on falling lock edge; clear bit holds it clear.
`timescale 1ns/1ps
module lock_detect_status_select (
    input wire logic i_clock, // System clock, 250 MHz
    input wire logic i_rst, // Synchronous reset, active high
    input wire logic [lock_detect_pkg::ADDR_W-1:0] i_addr, // Register address
    input wire logic [lock_detect_pkg::DATA_W-1:0] i_wdata, // Register write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [lock_detect_pkg::DATA_W-1:0] o_rdata, // Read data, cycle after i_rd
    input wire logic i_compare_valid, // Loop-two phase comparison done
    input wire logic i_in_window, // Comparison inside phase window
    input wire logic i_loop_one_lock, // Loop-one lock detect
    input wire logic i_holdover, // Holdover status
    input wire logic i_dac_locked, // DAC locked
    input wire logic i_readback_data, // Serial readback data
    input wire logic i_dac_rail, // DAC at rail
    input wire logic i_dac_low, // DAC low
    input wire logic i_dac_high, // DAC high
    input wire logic i_loop_one_n_div, // Loop-one N divider output
    input wire logic i_loop_two_n_div, // Loop-two N divider output
    input wire logic i_loop_one_r_div, // Loop-one R divider output
    input wire logic i_loop_two_r_div, // Loop-two R divider output
    output logic o_digital_lock_detect, // Loop-two lock detect
    output logic o_loop_two_lock_lost_flag, // Sticky lock-lost flag
    output logic o_lock_status_pin_two, // Status pin two drive value
    output logic o_lock_status_pin_two_oe, // Status pin two output enable
    output logic o_irq // Interrupt, level
);
    import lock_detect_pkg::*;

    // Configuration registers
    logic [5:0] count_high_q, count_high_d;
    logic [7:0] count_low_q, count_low_d;
    logic [4:0] sel_two_q, sel_two_d;
    logic [2:0] type_two_q, type_two_d;
    logic [4:0] sel_one_q, sel_one_d;
    logic lost_clear_q, lost_clear_d;
    logic [IRQ_W-1:0] irq_en_q, irq_en_d;

    // Status state
    logic lost_flag_q, lost_flag_d;
    logic lock_prev_q, lock_prev_d;
    logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [DIV_COUNT-1:0] div_prev_q, div_prev_d;
    logic [DIV_COUNT-1:0] div_half_q, div_half_d;

    logic [COUNT_W-1:0] threshold;
    logic lock;
    logic lock_rise, lock_fall;
    logic readback_lock;
    logic pin_level;
    logic [DIV_COUNT-1:0] div_in;
    logic wr_hit_high, wr_hit_low, wr_hit_cfg, wr_hit_clr, wr_hit_sel1;
    logic wr_hit_en, wr_hit_iclr;

    assign threshold = {count_high_q, count_low_q};
    assign div_in = {i_loop_two_r_div, i_loop_one_r_div, i_loop_two_n_div, i_loop_one_n_div};

    // Consecutive-cycle lock counter
    lock_counter #(
        .COUNT_W(COUNT_W)
    ) u_counter (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_compare_valid(i_compare_valid),
        .i_in_window(i_in_window),
        .i_threshold(threshold),
        .o_lock(lock)
    );

    // Write address decode
    always_comb begin
        wr_hit_high = 1'b0;
        wr_hit_low = 1'b0;
        wr_hit_cfg = 1'b0;
        wr_hit_clr = 1'b0;
        wr_hit_sel1 = 1'b0;
        wr_hit_en = 1'b0;
        wr_hit_iclr = 1'b0;
        if (i_addr == OFF_LOCK_COUNT_HIGH) begin
            wr_hit_high = i_wr;
        end else if (i_addr == OFF_LOCK_COUNT_LOW) begin
            wr_hit_low = i_wr;
        end else if (i_addr == OFF_STATUS_PIN_TWO_CONFIG) begin
            wr_hit_cfg = i_wr;
        end else if (i_addr == OFF_LOST_CLEAR) begin
            wr_hit_clr = i_wr;
        end else if (i_addr == OFF_STATUS_ONE_SELECT) begin
            wr_hit_sel1 = i_wr;
        end else if (i_addr == OFF_IRQ_ENABLE) begin
            wr_hit_en = i_wr;
        end else if (i_addr == OFF_IRQ_CLEAR) begin
            wr_hit_iclr = i_wr;
        end
    end

    // Next values of the software-written registers
    always_comb begin
        count_high_d = count_high_q;
        count_low_d = count_low_q;
        sel_two_d = sel_two_q;
        type_two_d = type_two_q;
        sel_one_d = sel_one_q;
        lost_clear_d = lost_clear_q;
        irq_en_d = irq_en_q;
        if (wr_hit_high) begin
            count_high_d = i_wdata[COUNT_HIGH_MSB:0];
        end
        if (wr_hit_low) begin
            count_low_d = i_wdata;
        end
        if (wr_hit_cfg) begin
            sel_two_d = i_wdata[SEL_MSB:SEL_LSB];
            type_two_d = i_wdata[TYPE_MSB:TYPE_LSB];
        end
        if (wr_hit_clr) begin
            lost_clear_d = i_wdata[0];
        end
        if (wr_hit_sel1) begin
            sel_one_d = i_wdata[SEL_MSB:SEL_LSB];
        end
        if (wr_hit_en) begin
            irq_en_d = i_wdata[IRQ_W-1:0];
        end
    end

    // Configuration registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_high_q <= RST_COUNT_HIGH;
            count_low_q <= RST_COUNT_LOW;
            sel_two_q <= RST_SEL_TWO;
            type_two_q <= RST_TYPE_TWO;
            sel_one_q <= RST_SEL_ONE;
            lost_clear_q <= 1'b0;
            irq_en_q <= '0;
        end else begin
            count_high_q <= count_high_d;
            count_low_q <= count_low_d;
            sel_two_q <= sel_two_d;
            type_two_q <= type_two_d;
            sel_one_q <= sel_one_d;
            lost_clear_q <= lost_clear_d;
            irq_en_q <= irq_en_d;
        end
    end

    assign lock_rise = lock && !lock_prev_q;
    assign lock_fall = !lock && lock_prev_q;

    // Readback only reflects lock while a pin routes it; otherwise the
    // detector's level is not meant to be observed
    assign readback_lock = (routes_loop_two(sel_one_q) || routes_loop_two(sel_two_q))
        && lock;

    // Lock-lost flag, edge history and interrupt status
    always_comb begin
        lock_prev_d = lock;
        lost_flag_d = lost_flag_q;
        if (lost_clear_q) begin
            lost_flag_d = 1'b0; // Clear bit held high keeps the flag clear
        end else if (lock_fall) begin
            lost_flag_d = 1'b1;
        end
        irq_stat_d = irq_stat_q;
        if (wr_hit_iclr) begin
            irq_stat_d = irq_stat_q & ~i_wdata[IRQ_W-1:0];
        end
        // Set after clear so an event in the clearing cycle is kept
        if (lock_rise) begin
            irq_stat_d[IRQ_LOCK_GAINED] = 1'b1;
        end
        if (lock_fall) begin
            irq_stat_d[IRQ_LOCK_LOST] = 1'b1;
        end
    end

    // Status registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            lock_prev_q <= 1'b0;
            lost_flag_q <= 1'b0;
            irq_stat_q <= '0;
        end else begin
            lock_prev_q <= lock_prev_d;
            lost_flag_q <= lost_flag_d;
            irq_stat_q <= irq_stat_d;
        end
    end

    // Half-rate divider copies toggle on each rising divider edge
    always_comb begin
        div_prev_d = div_in;
        div_half_d = div_half_q;
        for (int i = 0; i < DIV_COUNT; i++) begin
            if (div_in[i] && !div_prev_q[i]) begin
                div_half_d[i] = !div_half_q[i];
            end
        end
    end

    // Divider edge history
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            div_prev_q <= div_in; // No false edge after reset
            div_half_q <= '0;
        end else begin
            div_prev_q <= div_prev_d;
            div_half_q <= div_half_d;
        end
    end

    // Source selector for pin two
    always_comb begin
        pin_level = 1'b0;
        case (sel_two_q)
            SRC_LOW: pin_level = 1'b0;
            SRC_LOOP_ONE_LOCK: pin_level = i_loop_one_lock;
            SRC_LOOP_TWO_LOCK: pin_level = lock;
            SRC_BOTH_LOCK: pin_level = i_loop_one_lock && lock;
            SRC_HOLDOVER: pin_level = i_holdover;
            SRC_DAC_LOCKED: pin_level = i_dac_locked;
            SRC_RESERVED: pin_level = 1'b0;
            SRC_READBACK: pin_level = i_readback_data;
            SRC_DAC_RAIL: pin_level = i_dac_rail;
            SRC_DAC_LOW: pin_level = i_dac_low;
            SRC_DAC_HIGH: pin_level = i_dac_high;
            SRC_ONE_N: pin_level = i_loop_one_n_div;
            SRC_ONE_N_HALF: pin_level = div_half_q[DIV_ONE_N];
            SRC_TWO_N: pin_level = i_loop_two_n_div;
            SRC_TWO_N_HALF: pin_level = div_half_q[DIV_TWO_N];
            SRC_ONE_R: pin_level = i_loop_one_r_div;
            SRC_ONE_R_HALF: pin_level = div_half_q[DIV_ONE_R];
            // Loop-two R shares the detector's routing: held low while
            // pin one uses loop-two lock
            SRC_TWO_R: pin_level = !uses_loop_two(sel_one_q) && i_loop_two_r_div;
            SRC_TWO_R_HALF: begin
                pin_level = !uses_loop_two(sel_one_q) && div_half_q[DIV_TWO_R];
            end
            default: pin_level = 1'b0;
        endcase
    end

    // Pin two output stage
    status_pin_driver u_pin_two (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_level(pin_level),
        .i_type(type_two_q),
        .o_pin(o_lock_status_pin_two),
        .o_pin_oe(o_lock_status_pin_two_oe)
    );

    // Read mux; unmapped and write-only addresses read zero
    always_comb begin
        rdata_d = '0;
        if (i_rd) begin
            if (i_addr == OFF_LOCK_COUNT_HIGH) begin
                rdata_d = {2'h0, count_high_q};
            end else if (i_addr == OFF_LOCK_COUNT_LOW) begin
                rdata_d = count_low_q;
            end else if (i_addr == OFF_STATUS_PIN_TWO_CONFIG) begin
                rdata_d = {sel_two_q, type_two_q};
            end else if (i_addr == OFF_LOST_CLEAR) begin
                rdata_d = {7'h00, lost_clear_q};
            end else if (i_addr == OFF_LOCK_READBACK) begin
                rdata_d = {5'h00, i_loop_one_lock, lost_flag_q, readback_lock};
            end else if (i_addr == OFF_STATUS_ONE_SELECT) begin
                rdata_d = {sel_one_q, 3'h0};
            end else if (i_addr == OFF_IRQ_STATUS) begin
                rdata_d = {6'h00, irq_stat_q};
            end else if (i_addr == OFF_IRQ_ENABLE) begin
                rdata_d = {6'h00, irq_en_q};
            end
        end
    end

    // Read data stands for exactly one cycle
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_digital_lock_detect = lock;
    assign o_loop_two_lock_lost_flag = lost_flag_q;
    assign o_irq = |(irq_stat_q & irq_en_q);
endmodule // lock_detect_status_select

// ---- tb/lock_detect_status_select_asserts.sv ----
/* Port-level checker for lock_detect_status_select.
   Assumes one clock domain and the synchronous active-high reset. */
`timescale 1ns/1ps
module lock_detect_status_select_asserts
    import lock_detect_pkg::*;
(
    input wire logic i_clock, // Clock
    input wire logic i_rst, // Reset
    input wire logic [ADDR_W-1:0] i_addr, // Address
    input wire logic [DATA_W-1:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    input wire logic [DATA_W-1:0] o_rdata, // Read data
    input wire logic i_compare_valid, // Compare done
    input wire logic i_in_window, // Compare in window
    input wire logic o_digital_lock_detect, // Lock
    input wire logic o_loop_two_lock_lost_flag, // Lost flag
    input wire logic o_lock_status_pin_two, // Pin value
    input wire logic o_lock_status_pin_two_oe, // Pin enable
    input wire logic o_irq // Interrupt
);
    logic clr_q, clr_d;
    logic [2:0] type_q, type_d;

    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // Shadows of lost-clear and pin type, not visible at a port
    always_comb begin
        clr_d = (i_wr && i_addr == OFF_LOST_CLEAR) ? i_wdata[0] : clr_q;
        type_d = (i_wr && i_addr == OFF_STATUS_PIN_TWO_CONFIG) ? i_wdata[2:0] : type_q;
    end

    // Registered copies, reset like the device
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            clr_q <= 1'b0;
            type_q <= RST_TYPE_TWO;
        end else begin
            clr_q <= clr_d;
            type_q <= type_d;
        end
    end

    property p_high_byte;
        $past(i_rd) && $past(i_addr) == OFF_LOCK_COUNT_HIGH |-> o_rdata[7:6] == 2'b00;
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high bits set");
    property p_lock_rise;
        $rose(o_digital_lock_detect) |-> $past(i_compare_valid && i_in_window);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock rose unprompted");
    property p_restart;
        i_compare_valid && !i_in_window |=> !o_digital_lock_detect;
    endproperty
    a_restart: assert property (p_restart) else $error("lock held");
    property p_lost_set;
        $fell(o_digital_lock_detect) && !clr_q |=> o_loop_two_lock_lost_flag;
    endproperty
    a_lost_set: assert property (p_lost_set) else $error("lost flag missed");
    property p_lost_cause;
        $rose(o_loop_two_lock_lost_flag) |->
            $past(o_digital_lock_detect, 2) && !$past(o_digital_lock_detect);
    endproperty
    a_lost_cause: assert property (p_lost_cause) else $error("lost flag unprompted");
    property p_lost_clear;
        clr_q |=> !o_loop_two_lock_lost_flag;
    endproperty
    a_lost_clear: assert property (p_lost_clear) else $error("lost flag not held");
    property p_type_reserved;
        !(type_q inside {3'h3, 3'h4, 3'h6}) && $stable(type_q) |->
            !o_lock_status_pin_two_oe && !o_lock_status_pin_two;
    endproperty
    a_type_reserved: assert property (p_type_reserved) else $error("reserved type drives pin");
    property p_open_drain;
        type_q == TYPE_OPEN_DRAIN && $stable(type_q) |-> !o_lock_status_pin_two;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high");
    property p_push_pull;
        type_q inside {3'h3, 3'h4} && $stable(type_q) |-> o_lock_status_pin_two_oe;
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("pin not driven");

    c_lock: cover property ($rose(o_digital_lock_detect));
    c_lost: cover property ($rose(o_loop_two_lock_lost_flag));
    c_irq: cover property ($rose(o_irq));
endmodule // lock_detect_status_select_asserts

bind lock_detect_status_select lock_detect_status_select_asserts i_asserts (.*);

// ---- tb/lock_detect_status_select_tb.sv ----
/* Self-checking bench for lock_detect_status_select.
   Assumes one-cycle read latency. */
`timescale 1ns/1ps
module lock_detect_status_select_tb;
    import lock_detect_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst, i_wr, i_rd, i_compare_valid, i_in_window;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata;
    logic i_loop_one_lock, i_holdover, i_dac_locked, i_readback_data, i_dac_rail, i_dac_low;
    logic i_dac_high, i_loop_one_n_div, i_loop_two_n_div, i_loop_one_r_div, i_loop_two_r_div;
    logic o_digital_lock_detect, o_loop_two_lock_lost_flag, o_lock_status_pin_two;
    logic o_lock_status_pin_two_oe, o_irq;
    logic rd_q = 1'b0;
    logic [7:0] exp_q[$];
    logic [2:0] ty[5] = '{3'h3, 3'h4, 3'h6, 3'h0, 3'h5};
    logic e;
    logic [17:0] lv;
    int n_mismatch = 0;
    int n_compared = 0;
    int n;

    // Expected level per code
    assign lv = {i_loop_two_r_div, 1'b0, i_loop_one_r_div, 1'b0, i_loop_two_n_div, 1'b0,
        i_loop_one_n_div, i_dac_high, i_dac_low, i_dac_rail, i_readback_data, 1'b0,
        i_dac_locked, i_holdover, 2'b00, i_loop_one_lock, 1'b0};

    lock_detect_status_select i_lock_detect_status_select (.*);

    // 250 MHz clock
    always #2 i_clock = ~i_clock;

    task automatic chk(input logic [7:0] e, input logic [7:0] a);
        n_compared++;
        if (a !== e) begin
            n_mismatch++;
            $display("Error at %0t: expected %h, got %h", $time, e, a);
        end
    endtask

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge i_clock) begin
        if (rd_q) chk(exp_q.pop_front(), o_rdata);
        rd_q <= i_rd;
    end

    // Strobe high for one edge
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge i_clock);
        i_rd <= 1'b0;
    endtask

    // One comparison; returns just after the edge that took it
    task automatic cmp(input logic inw);
        @(posedge i_clock);
        i_compare_valid <= 1'b1;
        i_in_window <= inw;
        @(posedge i_clock);
        i_compare_valid <= 1'b0;
        #1;
    endtask

    task automatic settle();
        repeat (2) @(posedge i_clock);
        #1;
    endtask

    // Run needs under 2000 cycles; limit 20000
    initial begin
        #80000;
        n_mismatch++;
        finish_test();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h6846b9dc));
        i_rst <= 1'b1;
        {i_wr, i_rd, i_compare_valid, i_in_window, i_addr, i_wdata} <= '0;
        {i_loop_one_lock, i_holdover, i_dac_locked, i_readback_data, i_dac_rail, i_dac_low,
            i_dac_high, i_loop_one_n_div, i_loop_two_n_div, i_loop_one_r_div,
            i_loop_two_r_div} <= 11'($urandom);
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(OFF_LOCK_COUNT_HIGH, 8'h00);
        rd(OFF_LOCK_COUNT_LOW, 8'h00);
        rd(OFF_STATUS_PIN_TWO_CONFIG, 8'h06);
        rd(9'h100, 8'h00);
        wr(OFF_LOCK_COUNT_HIGH, 8'hff);
        rd(OFF_LOCK_COUNT_HIGH, 8'h3f);
        wr(OFF_LOCK_COUNT_HIGH, 8'h00);
        for (int c = 0; c < 18; c++) begin
            if (c inside {12, 14, 16}) continue;
            wr(OFF_STATUS_PIN_TWO_CONFIG, {c[4:0], TYPE_PUSH_PULL});
            settle();
            chk({7'h00, lv[c]}, o_lock_status_pin_two);
        end
        @(posedge i_clock);
        i_loop_two_r_div <= 1'b1;
        wr(OFF_STATUS_PIN_TWO_CONFIG, {SRC_TWO_R, TYPE_PUSH_PULL});
        settle();
        chk(8'h01, o_lock_status_pin_two);
        wr(OFF_STATUS_ONE_SELECT, {SRC_LOOP_TWO_LOCK, 3'h0});
        settle();
        chk(8'h00, o_lock_status_pin_two);
        wr(OFF_STATUS_ONE_SELECT, 8'h00);
        for (int l = 0; l < 2; l++) begin
            @(posedge i_clock);
            i_loop_one_lock <= l[0];
            foreach (ty[k]) begin
                wr(OFF_STATUS_PIN_TWO_CONFIG, {SRC_LOOP_ONE_LOCK, ty[k]});
                settle();
                e = ty[k] == 3'h3 ? l[0] : ty[k] == 3'h4 && !l[0];
                chk(e, o_lock_status_pin_two);
                e = ty[k] == 3'h6 ? !l[0] : ty[k] inside {3'h3, 3'h4};
                chk(e, o_lock_status_pin_two_oe);
            end
        end
        n = 2 + $urandom % 4;
        wr(OFF_LOCK_COUNT_LOW, 8'(n));
        repeat (n - 1) cmp(1'b1);
        cmp(1'b0);
        repeat (n - 1) cmp(1'b1);
        chk(8'h00, o_digital_lock_detect);
        cmp(1'b1);
        chk(8'h01, o_digital_lock_detect);
        rd(OFF_IRQ_STATUS, 8'h01);
        wr(OFF_IRQ_ENABLE, 8'h02);
        settle();
        chk(8'h00, o_irq);
        cmp(1'b0);
        chk(8'h00, o_digital_lock_detect);
        @(posedge i_clock);
        #1;
        chk(8'h01, o_loop_two_lock_lost_flag);
        chk(8'h01, o_irq);
        rd(OFF_LOCK_READBACK, {5'h00, i_loop_one_lock, 2'b10});
        rd(OFF_IRQ_STATUS, 8'h03);
        wr(OFF_IRQ_CLEAR, 8'h03);
        rd(OFF_IRQ_STATUS, 8'h00);
        settle();
        chk(8'h00, o_irq);
        wr(OFF_LOST_CLEAR, 8'h01);
        settle();
        chk(8'h00, o_loop_two_lock_lost_flag);
        wr(OFF_LOST_CLEAR, 8'h00);
        wr(OFF_STATUS_PIN_TWO_CONFIG, {SRC_LOOP_TWO_LOCK, TYPE_PUSH_PULL});
        repeat (n) cmp(1'b1);
        rd(OFF_LOCK_READBACK, {5'h00, i_loop_one_lock, 2'b01});
        settle();
        chk(8'h01, o_lock_status_pin_two);
        wr(OFF_STATUS_PIN_TWO_CONFIG, {SRC_BOTH_LOCK, TYPE_PUSH_PULL});
        rd(OFF_LOCK_READBACK, {5'h00, i_loop_one_lock, 2'b00});
        settle();
        chk({7'h00, i_loop_one_lock}, o_lock_status_pin_two);
        cmp(1'b0);
        wr(OFF_LOCK_COUNT_HIGH, 8'h01);
        wr(OFF_LOCK_COUNT_LOW, 8'h00);
        repeat (255) cmp(1'b1);
        chk(8'h00, o_digital_lock_detect);
        cmp(1'b1);
        chk(8'h01, o_digital_lock_detect);
        wr(OFF_LOCK_COUNT_HIGH, 8'h00);
        repeat (3) cmp(1'b1);
        chk(8'h00, o_digital_lock_detect);
        settle();
        finish_test();
    end
endmodule // lock_detect_status_select_tb
